// file: core/tms_consts.svh
// constants of the torque mode sequencer: widths, ranges, reset values, timing
// assumes a 10 MHz clk_i; analog values arrive already converted to digital words
//
// Functional notes
// - select inputs form index 0..7, select_bit0 is the least significant bit.
// - analog enable makes entries 0 and 1 analog, entries 2..7 digital.
// - one index picks both torque command and speed limit.
// - system settings are latched once after reset release only.
// - entry 0 torque comes from torque_pot, 0..300 percent, default zero.
// - entry 1 torque is volts times analog_torque_gain, 0..300, default 30.
// - offset from stored setting, or captured at zero volts when auto.
// - direction polarity maps clockwise input to clockwise or swaps both.
// - a negative torque command reverses the resulting direction.
// - run input after selection starts torque at the selected command.
// - torque drops to zero on run release or both run inputs on.
// - excitation stays about 20 ms after a run input is released.
// - ready shows operation possible and is low while operating.
// - ready low on no power, alarm, free, run input, tool mode.
// - motion output stays high at least the configured minimum on-time.
// - output selections gate motion, brake-release and zero-speed outputs.
// - brake-release high while brake released, low while brake holds.
// - zero-speed output high while speed lies within zero-speed band.
// - speed-limited output high when speed reaches selected limit.
// - free-shaft input cuts motor current entirely.
// - free-shaft input releases a holding brake too.
// - entry 0 speed limit comes from speed_limit_pot, 0..5500 r/min.
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH

`define TMS_TRQ_W        16
`define TMS_SPD_W        16
`define TMS_TRQ_MAX      16'sd300
`define TMS_SPD_MAX      16'sd5500
`define TMS_GAIN_INIT    16'd30
`define TMS_GAIN_MAX     16'd300
`define TMS_TRQ_ZERO     16'sd0
`define TMS_SPD_ZERO     16'sd0
`define TMS_MV_PER_V     32'sd1000
`define TMS_CLK_HZ       10000000
`define TMS_EXCITE_MS    20
`define TMS_EXCITE_CYC   ((`TMS_CLK_HZ / 1000) * `TMS_EXCITE_MS)
`define TMS_CNT_W        24
`define TMS_IDX_ANA0     3'h0
`define TMS_IDX_ANA1     3'h1
`define TMS_MIN_ON_US    10000
`define TMS_CYC_PER_US   (`TMS_CLK_HZ / 1000000)

`endif

// file: core/tms_pkg.sv
// types of the torque mode sequencer
// assumes tms_consts.svh for widths
`include "tms_consts.svh"

package tms_pkg;

    typedef enum logic [1:0]
    {
        TMS_IDLE,
        TMS_RUN,
        TMS_HOLD
    } tms_state_t;

    // settings that only take effect after a reset
    typedef struct packed
    {
        logic analog_select_enable;
        logic direction_polarity;
    } tms_sys_t;

    // status outputs
    typedef struct packed
    {
        logic ready;
        logic motion;
        logic brake_release_out;
        logic zero_speed_out;
        logic speed_limited_out;
    } tms_status_t;

endpackage

// file: core/tms_sequencer.sv
// torque mode sequencer: entry selection, run sequencing, status outputs
// assumes analog words already digitised; motor loop consumes torque/direction
`timescale 1ns/1ps
`include "tms_consts.svh"

module tms_sequencer
#(
    parameter int EXCITE_CYC = `TMS_EXCITE_CYC
)
(
    // clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rstn_i,
    // select, run and free pins
    input  wire logic                                select_bit0_i,
    input  wire logic                                select_bit1_i,
    input  wire logic                                select_bit2_i,
    input  wire logic                                run_clockwise_in_i,
    input  wire logic                                run_counter_clockwise_in_i,
    input  wire logic                                free_i,
    // system settings, latched after reset
    input  wire tms_pkg::tms_sys_t                   sys_i,
    // application settings
    input  wire logic [`TMS_TRQ_W-1:0]               analog_torque_gain_i,
    input  wire logic signed [`TMS_TRQ_W-1:0]        analog_torque_offset_i,
    input  wire logic                                auto_offset_enable_i,
    input  wire logic                                offset_capture_i,
    input  wire logic                                output_select_first_i,
    input  wire logic                                output_select_second_i,
    input  wire logic [`TMS_SPD_W-1:0]               zero_speed_band_i,
    input  wire logic [`TMS_CNT_W-1:0]               motion_min_on_time_i,
    // digital operation data entries
    input  wire logic signed [8*`TMS_TRQ_W-1:0]      torque_data_i,
    input  wire logic signed [8*`TMS_SPD_W-1:0]      speed_data_i,
    // analog sources, digitised
    input  wire logic [`TMS_TRQ_W-1:0]               torque_pot_i,
    input  wire logic [`TMS_SPD_W-1:0]               speed_limit_pot_i,
    input  wire logic signed [`TMS_TRQ_W-1:0]        ext_torque_mv_i,
    input  wire logic signed [`TMS_SPD_W-1:0]        ext_speed_limit_i,
    // device state
    input  wire logic                                main_power_i,
    input  wire logic                                alarm_i,
    input  wire logic                                tool_mode_i,
    input  wire logic signed [`TMS_SPD_W-1:0]        speed_i,
    // motor control outputs
    output logic signed [`TMS_TRQ_W-1:0]             torque_cmd_o,
    output logic [`TMS_SPD_W-1:0]                    speed_limit_o,
    output logic                                     dir_ccw_o,
    output logic                                     excite_o,
    // status
    output tms_pkg::tms_status_t                     status_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s3_reg;
    logic [NSYNC-1:0] pin_reg;

    assign pin_raw = {free_i, run_counter_clockwise_in_i, run_clockwise_in_i,
                      select_bit2_i, select_bit1_i, select_bit0_i};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    s1_reg[g]  <= 1'b0;
                    s2_reg[g]  <= 1'b0;
                    s3_reg[g]  <= 1'b0;
                    pin_reg[g] <= 1'b0;
                end
                else
                begin
                    s1_reg[g] <= pin_raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g])
                        pin_reg[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

    logic [2:0] sel_idx;
    logic       run_cw;
    logic       run_ccw;
    logic       free_s;
    assign sel_idx = pin_reg[2:0];
    assign run_cw  = pin_reg[3];
    assign run_ccw = pin_reg[4];
    assign free_s  = pin_reg[5];

    // ------------------------------------------------------------
    // system settings latch
    // ------------------------------------------------------------
    tms_pkg::tms_sys_t sys_reg;
    logic              sys_done_reg;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sys_reg      <= '0;
            sys_done_reg <= 1'b0;
        end
        else if (!sys_done_reg)
        begin
            sys_reg      <= sys_i;
            sys_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // analog offset and entry selection
    // ------------------------------------------------------------
    logic signed [`TMS_TRQ_W-1:0] auto_off_reg;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            auto_off_reg <= `TMS_TRQ_ZERO;
        else if (auto_offset_enable_i && offset_capture_i)
            auto_off_reg <= ext_torque_mv_i;
    end

    function automatic logic signed [`TMS_TRQ_W-1:0] clamp_trq(input logic signed [31:0] v);
        if (v > 32'(`TMS_TRQ_MAX))
            clamp_trq = `TMS_TRQ_MAX;
        else if (v < -32'(`TMS_TRQ_MAX))
            clamp_trq = -`TMS_TRQ_MAX;
        else
            clamp_trq = v[`TMS_TRQ_W-1:0];
    endfunction

    function automatic logic [`TMS_SPD_W-1:0] clamp_spd(input logic signed [31:0] v);
        if (v > 32'(`TMS_SPD_MAX))
            clamp_spd = `TMS_SPD_MAX;
        else if (v < 32'sd0)
            clamp_spd = `TMS_SPD_ZERO;
        else
            clamp_spd = v[`TMS_SPD_W-1:0];
    endfunction

    logic signed [`TMS_TRQ_W-1:0] off_sel;
    logic [`TMS_TRQ_W-1:0]        gain_eff;
    logic signed [31:0]           ana1_trq;
    logic signed [`TMS_TRQ_W-1:0] sel_trq;
    logic [`TMS_SPD_W-1:0]        sel_spd;
    logic                         use_ana;

    assign off_sel  = auto_offset_enable_i ? auto_off_reg : analog_torque_offset_i;
    assign gain_eff = (analog_torque_gain_i > `TMS_GAIN_MAX) ? `TMS_GAIN_MAX
                                                              : analog_torque_gain_i;
    assign ana1_trq = ((32'(ext_torque_mv_i) - 32'(off_sel)) * 32'(signed'({1'b0, gain_eff})))
                      / `TMS_MV_PER_V;
    assign use_ana  = sys_reg.analog_select_enable;

    always_comb
    begin
        // same index drives both values
        sel_trq = clamp_trq(32'(signed'(torque_data_i[sel_idx*`TMS_TRQ_W +: `TMS_TRQ_W])));
        sel_spd = clamp_spd(32'(signed'(speed_data_i[sel_idx*`TMS_SPD_W +: `TMS_SPD_W])));
        if (use_ana && sel_idx == `TMS_IDX_ANA0)
        begin
            sel_trq = clamp_trq(32'(signed'({1'b0, torque_pot_i})));
            sel_spd = clamp_spd(32'(signed'({1'b0, speed_limit_pot_i})));
        end
        else if (use_ana && sel_idx == `TMS_IDX_ANA1)
        begin
            sel_trq = clamp_trq(ana1_trq);
            sel_spd = clamp_spd(32'(ext_speed_limit_i));
        end
    end

    // ------------------------------------------------------------
    // run sequencing
    // ------------------------------------------------------------
    tms_pkg::tms_state_t     state_reg;
    logic [`TMS_CNT_W-1:0]   hold_cnt_reg;
    logic                    run_one;
    logic                    can_run;

    assign run_one = run_cw ^ run_ccw;
    assign can_run = main_power_i && !alarm_i && !free_s && !tool_mode_i;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg    <= tms_pkg::TMS_IDLE;
            hold_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                tms_pkg::TMS_IDLE:
                begin
                    if (run_one && can_run)
                        state_reg <= tms_pkg::TMS_RUN;
                end
                tms_pkg::TMS_RUN:
                begin
                    if (!run_one || !can_run)
                    begin
                        state_reg    <= tms_pkg::TMS_HOLD;
                        hold_cnt_reg <= `TMS_CNT_W'(EXCITE_CYC - 1);
                    end
                end
                tms_pkg::TMS_HOLD:
                begin
                    if (free_s)
                        state_reg <= tms_pkg::TMS_IDLE;
                    else if (hold_cnt_reg == '0)
                        state_reg <= tms_pkg::TMS_IDLE;
                    else
                        hold_cnt_reg <= hold_cnt_reg - 1'b1;
                end
                default:
                    state_reg <= tms_pkg::TMS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // motor command outputs
    // ------------------------------------------------------------
    logic operating;
    logic dir_base;
    assign operating = (state_reg == tms_pkg::TMS_RUN) && run_one && can_run;
    assign dir_base  = run_ccw ^ sys_reg.direction_polarity;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            torque_cmd_o  <= `TMS_TRQ_ZERO;
            speed_limit_o <= `TMS_SPD_ZERO;
            dir_ccw_o     <= 1'b0;
            excite_o      <= 1'b0;
        end
        else
        begin
            torque_cmd_o  <= operating ? sel_trq : `TMS_TRQ_ZERO;
            speed_limit_o <= sel_spd;
            if (operating)
                dir_ccw_o <= dir_base ^ sel_trq[`TMS_TRQ_W-1];
            excite_o      <= (state_reg != tms_pkg::TMS_IDLE) && !free_s;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    logic [`TMS_CNT_W-1:0] min_on_reg;
    logic signed [`TMS_SPD_W:0] spd_abs;
    assign spd_abs = speed_i[`TMS_SPD_W-1] ? -(`TMS_SPD_W+1)'(speed_i)
                                            : (`TMS_SPD_W+1)'(speed_i);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            min_on_reg <= '0;
        else if (operating)
            min_on_reg <= motion_min_on_time_i;
        else if (min_on_reg != '0)
            min_on_reg <= min_on_reg - 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            status_o <= '0;
        else
        begin
            status_o.ready             <= can_run && !run_cw && !run_ccw
                                          && (state_reg == tms_pkg::TMS_IDLE);
            status_o.motion            <= output_select_first_i
                                          && (operating || min_on_reg != '0);
            status_o.brake_release_out <= output_select_first_i
                                          && (excite_o || free_s);
            status_o.zero_speed_out    <= output_select_second_i
                                          && (spd_abs <= $signed({1'b0, zero_speed_band_i}));
            status_o.speed_limited_out <= operating
                                          && (spd_abs >= $signed({1'b0, sel_spd}));
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_both_runs_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (run_cw && run_ccw) |=> torque_cmd_o == `TMS_TRQ_ZERO)
        else $error("torque not zero with both run inputs");
    chk_ready_while_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
        operating |=> !status_o.ready)
        else $error("ready high while operating");
    chk_ready_free_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        free_s |=> !status_o.ready)
        else $error("ready high with free input");
    chk_excite_hold_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg == tms_pkg::TMS_RUN && !run_one && !free_s)
        |=> ##1 (excite_o || $past(free_s)))
        else $error("excitation dropped at run release");
    chk_motion_gate_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !output_select_first_i |=> !status_o.motion)
        else $error("motion output without selection");
    chk_motion_min_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ($fell(operating) && output_select_first_i && $past(output_select_first_i)
         && motion_min_on_time_i > 1) |=> status_o.motion)
        else $error("motion dropped before minimum on time");
    chk_free_brake_rel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (free_s && output_select_first_i) |=> status_o.brake_release_out)
        else $error("brake not released with free input");
    chk_free_no_excite: assert property (@(posedge clk_i) disable iff (!rstn_i)
        free_s |=> !excite_o)
        else $error("motor excited with free input");
    chk_sys_stable: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(sys_done_reg) |-> $stable(sys_reg))
        else $error("system setting changed after latch");

endmodule // tms_sequencer

// file: test/tms_ctl_model.sv
// controller model: drives the entry select pins and the run pins
// assumes the bench calls its tasks; pins change only at the falling edge
`timescale 1ns/1ps

module tms_ctl_model
(
    // clock and status from the sequencer
    input  wire logic clk_i,
    input  wire logic ready_i,
    // pins towards the sequencer
    output logic      sel0_o,
    output logic      sel1_o,
    output logic      sel2_o,
    output logic      cw_o,
    output logic      ccw_o
);
    initial
    begin
        {sel2_o, sel1_o, sel0_o, cw_o, ccw_o} = 5'h00;
    end

    // entry index, bit 0 least significant
    task automatic pick(input logic [2:0] idx);
        @(negedge clk_i);
        {sel2_o, sel1_o, sel0_o} = idx;
    endtask

    // a start waits for ready unless the bench forces it
    task automatic run(input logic cw, input logic run_counter_clockwise_in, input logic go);
        int n;
        n = 0;
        while (!go && ready_i !== 1'b1 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        cw_o  = cw;
        ccw_o = run_counter_clockwise_in;
    endtask
endmodule // tms_ctl_model

// file: test/torque_mode_sequencer_tb.sv
// self-checking bench of the torque mode sequencer
// assumes tms_pkg and tms_consts.svh compiled; 10 MHz clock
`timescale 1ns/1ps
`include "tms_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end

module torque_mode_sequencer_tb;
    logic                         clk, rstn, free, s0, s1, s2, cw, run_counter_clockwise_in;
    logic                         auto_off, capt, osel1, osel2, power, alarm, tool;
    logic                         dccw, exc;
    tms_pkg::tms_sys_t            sys;
    tms_pkg::tms_status_t         st;
    logic [15:0]                  gain, band, tpot, spot;
    logic signed [15:0]           offs, ext_mv, ext_spd, speed, trq;
    logic [15:0]                  lim;
    logic [23:0]                  min_on;
    logic signed [127:0]          tdat, sdat;
    int                           n_fail = 0;
    int                           checks = 0;

    tms_sequencer #(.EXCITE_CYC(20)) u_dut (.clk_i(clk), .rstn_i(rstn),
        .select_bit0_i(s0), .select_bit1_i(s1), .select_bit2_i(s2),
        .run_clockwise_in_i(cw), .run_counter_clockwise_in_i(run_counter_clockwise_in), .free_i(free),
        .sys_i(sys), .analog_torque_gain_i(gain), .analog_torque_offset_i(offs),
        .auto_offset_enable_i(auto_off), .offset_capture_i(capt),
        .output_select_first_i(osel1), .output_select_second_i(osel2),
        .zero_speed_band_i(band), .motion_min_on_time_i(min_on),
        .torque_data_i(tdat), .speed_data_i(sdat), .torque_pot_i(tpot),
        .speed_limit_pot_i(spot), .ext_torque_mv_i(ext_mv), .ext_speed_limit_i(ext_spd),
        .main_power_i(power), .alarm_i(alarm), .tool_mode_i(tool), .speed_i(speed),
        .torque_cmd_o(trq), .speed_limit_o(lim), .dir_ccw_o(dccw), .excite_o(exc),
        .status_o(st));

    tms_ctl_model u_ctl (.clk_i(clk), .ready_i(st.ready), .sel0_o(s0), .sel1_o(s1),
        .sel2_o(s2), .cw_o(cw), .ccw_o(run_counter_clockwise_in));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic do_reset(input logic ana, input logic pol);
        rstn = 1'b0;
        sys  = '{analog_select_enable: ana, direction_polarity: pol};
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        sys  = '{analog_select_enable: ~ana, direction_polarity: ~pol};
    endtask

    task automatic do_run(input logic [2:0] idx, input logic c, input logic cc,
                          input logic signed [15:0] et, input logic [15:0] es,
                          input logic ed);
        int n;
        u_ctl.pick(idx);
        u_ctl.run(c, cc, 1'b0);
        n = 0;
        while (trq === 16'sh0000 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("torque", et, trq)
        `CHK("limit", es, lim)
        `CHK("dir", ed, dccw)
        `CHK("ready", 1'b0, st.ready)
        speed = es;
        repeat (6) @(negedge clk);
        `CHK("limited", 1'b1, st.speed_limited_out)
        `CHK("brake", 1'b1, st.brake_release_out)
        `CHK("zs_off", 1'b0, st.zero_speed_out)
        speed = 16'sh0000;
        u_ctl.run(1'b0, 1'b0, 1'b1);
        repeat (8) @(negedge clk);
        `CHK("stop", 16'sh0000, trq)
        `CHK("hold", 1'b1, exc)
        `CHK("motion", 1'b1, st.motion)
        repeat (50) @(negedge clk);
        `CHK("unexcite", 1'b0, exc)
        `CHK("motion_off", 1'b0, st.motion)
        `CHK("brake_off", 1'b0, st.brake_release_out)
        `CHK("zero_spd", 1'b1, st.zero_speed_out)
    endtask

    initial
    begin
        {free, auto_off, capt, osel1, osel2, alarm, tool} = 7'h00;
        power  = 1'b1;
        rstn   = 1'b0;
        gain   = 16'h001e;
        band   = 16'h000a;
        tpot   = 16'h0096;
        spot   = 16'h157c;
        offs   = 16'sh0000;
        ext_mv = 16'sh07d0;
        ext_spd = 16'sh04b0;
        speed  = 16'sh0000;
        min_on = 24'h000028;
        for (int k = 0; k < 8; k++)
        begin
            tdat[16*k +: 16] = (k == 3) ? -16'sd40 : 16'(10 * (k + 1));
            sdat[16*k +: 16] = 16'(100 * (k + 1));
        end
        osel1 = 1'b1;
        osel2 = 1'b1;
        do_reset(1'b0, 1'b0);
        for (int k = 0; k < 8; k++)
            do_run(3'(k), 1'b1, 1'b0, tdat[16*k +: 16], sdat[16*k +: 16], k == 3);
        do_run(3'h2, 1'b0, 1'b1, 16'sd30, 16'h012c, 1'b1);
        u_ctl.run(1'b1, 1'b1, 1'b0);
        repeat (10) @(negedge clk);
        `CHK("both", 16'sh0000, trq)
        `CHK("ready_run", 1'b0, st.ready)
        u_ctl.run(1'b0, 1'b0, 1'b1);
        repeat (40) @(negedge clk);
        `CHK("zs_on", 1'b1, st.zero_speed_out)
        osel2 = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("zs_gated", 1'b0, st.zero_speed_out)
        osel2 = 1'b1;
        for (int c = 0; c < 3; c++)
        begin
            alarm = (c == 0);
            power = (c != 1);
            tool  = (c == 2);
            u_ctl.run(1'b1, 1'b0, 1'b1);
            repeat (10) @(negedge clk);
            `CHK("refused", 16'sh0000, trq)
            `CHK("not_ready", 1'b0, st.ready)
            u_ctl.run(1'b0, 1'b0, 1'b1);
        end
        repeat (8) @(negedge clk);
        {alarm, tool, power} = 3'h1;
        repeat (40) @(negedge clk);
        free = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("free_exc", 1'b0, exc)
        `CHK("free_brake", 1'b1, st.brake_release_out)
        `CHK("free_ready", 1'b0, st.ready)
        free = 1'b0;
        do_reset(1'b1, 1'b1);
        do_run(3'h0, 1'b1, 1'b0, 16'sd150, 16'd5500, 1'b1);
        do_run(3'h1, 1'b1, 1'b0, 16'sd60, 16'd1200, 1'b1);
        offs = 16'sh03e8;
        do_run(3'h1, 1'b1, 1'b0, 16'sd30, 16'd1200, 1'b1);
        auto_off = 1'b1;
        ext_mv = 16'sh01f4;
        capt = 1'b1;
        @(negedge clk);
        capt = 1'b0;
        ext_mv = 16'sh09c4;
        do_run(3'h1, 1'b1, 1'b0, 16'sd60, 16'd1200, 1'b1);
        do_run(3'h5, 1'b0, 1'b1, 16'sd60, 16'd600, 1'b0);
        stop_test();
    end

    initial
    begin
        #4_000_000;
        n_fail++;
        stop_test();
    end
endmodule // torque_mode_sequencer_tb
